// file: pkg/fsbc_defines.vh
`ifndef FSBC_DEFINES_VH
`define FSBC_DEFINES_VH

// register byte offsets
`define FSBC_ADDR_TIMER     8'h0A
`define FSBC_ADDR_THERM     8'h0B
`define FSBC_ADDR_BLANK     8'h0C

// reset values and writable masks
`define FSBC_RST_TIMER      8'h00
`define FSBC_RST_THERM      8'h00
`define FSBC_RST_BLANK      8'hC0
`define FSBC_MASK_ALL       8'hFF
`define FSBC_MASK_THERM     8'h8F
`define FSBC_READ_NONE      8'h00

// watchdog_and_flash_timer fields
`define FSBC_WDOG_ON        7
`define FSBC_WDOG_SEL_HI    6
`define FSBC_WDOG_SEL_LO    5
`define FSBC_SAFE_MODE      4
`define FSBC_SAFE_SEL_HI    3
`define FSBC_SAFE_SEL_LO    0

// thermal_guard_control fields
`define FSBC_RESTART_POL    7
`define FSBC_THERM_ON       3
`define FSBC_THERM_THR_HI   2
`define FSBC_THERM_THR_LO   0

// transmit_blank_control fields
`define FSBC_BLANK_ON       7
`define FSBC_BLANK_POL      6
`define FSBC_CAP_HI         5
`define FSBC_CAP_LO         2
`define FSBC_REC_HI         1
`define FSBC_REC_LO         0

// timing, each in its own unit
`define FSBC_CLK_MHZ        100
`define FSBC_US_PER_MS      1000
`define FSBC_MS_PER_S       1000
`define FSBC_SAFETY_STEP_MS 50
`define FSBC_WDOG_STEP_S    4
`define FSBC_HOLD_LOW_MS    30
`define FSBC_REC_BASE_US    10

`endif

// file: hw/fsbc_reg8.v
`timescale 1ns/1ns
`default_nettype none
`include "fsbc_defines.vh"

// one 8-bit control register; bits outside the mask keep their reset value
module fsbc_reg8 #(
  parameter [7:0] ADDR = `FSBC_ADDR_TIMER,
  parameter [7:0] RST  = `FSBC_RST_TIMER,
  parameter [7:0] MASK = `FSBC_MASK_ALL
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       reg_wr,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] q
);

  // write on address match; reserved bits never take written data
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= RST;
    end else if (reg_wr && reg_addr == ADDR) begin
      q <= (q & ~MASK) | (reg_wdata & MASK);
    end
  end

endmodule
`default_nettype wire

// file: hw/fsbc_timer.v
`timescale 1ns/1ns
`default_nettype none

// up-counter that stops at its limit; done is a level while count >= limit
module fsbc_timer #(
  parameter W = 32
) (
  input  wire         core_clk,
  input  wire         nrst,
  input  wire         clr,
  input  wire         run,
  input  wire [W-1:0] limit,
  output wire         done
);

  reg [W-1:0] cnt;  // elapsed cycles

  // clear wins over run so a restart never carries old time
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= {W{1'b0}};
    end else if (clr) begin
      cnt <= {W{1'b0}};
    end else if (run && !done) begin
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // limit may change under a running count; done follows at once
  assign done = (cnt >= limit);

endmodule
`default_nettype wire

// file: hw/fsbc_top.v
// How it works
// - watchdog runs only while its enable set
// - watchdog code selects 4, 8, 12, 16 s
// - mode zero: one fixed-length flash, inputs ignored
// - supply low during one-shot forces power-down
// - mode one: any flash cut at limit
// - safety limit is 50 ms times code+1
// - policy zero: pin low 30 ms restarts
// - policy one: pin low restarts timer immediately
// - thermistor guard acts only while enabled
// - threshold code selects 200 to 550 mV
// - blank input honoured only while enabled
// - blank polarity bit chooses active level
// - blanking applies the programmed input current cap
// - recovery code selects 10, 20, 40, 80 us
// - codes 101/110/111 hand outputs to pin
`timescale 1ns/1ns
`default_nettype none
`include "fsbc_defines.vh"

module fsbc_top #(
  parameter [31:0] MS_CYCLES = `FSBC_CLK_MHZ * `FSBC_US_PER_MS,
  parameter [31:0] US_CYCLES = `FSBC_CLK_MHZ
) (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [2:0] flash_mode_code,
  input  wire       lamp_gate_input,
  input  wire       tx_blank_input,
  input  wire       logic_supply_ok,
  input  wire       thermistor_hot,
  output reg        first_flash_output,
  output reg        second_flash_output,
  output reg        power_down,
  output reg        safety_expired,
  output reg        watchdog_tripped,
  output reg        thermistor_cut,
  output wire [2:0] thermistor_threshold,
  output reg        blank_limit_active,
  output wire [3:0] blank_input_current_cap
);

  // derived cycle counts; long ones scale with the parameters above
  localparam [31:0] SAFETY_STEP_CYC = `FSBC_SAFETY_STEP_MS * MS_CYCLES;
  localparam [31:0] WDOG_STEP_CYC   = `FSBC_WDOG_STEP_S * `FSBC_MS_PER_S * MS_CYCLES;
  localparam [31:0] HOLD_LOW_CYC    = `FSBC_HOLD_LOW_MS * MS_CYCLES;
  localparam [31:0] REC_BASE_CYC    = `FSBC_REC_BASE_US * US_CYCLES;

  // flash sequencer states, one-hot
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_SHOT  = 5'h02;
  localparam [4:0] ST_LIT   = 5'h04;
  localparam [4:0] ST_SPENT = 5'h08;
  localparam [4:0] ST_DOWN  = 5'h10;

  // does the enable code ask for output idx, and who drives it
  function fsbc_want;
    input [2:0] code;
    input       idx;
    input       pin;
    begin
      if (code[2]) begin
        fsbc_want = code[idx] & pin;
      end else begin
        fsbc_want = code[idx];
      end
    end
  endfunction

  wire [7:0] timer_reg;  // watchdog_and_flash_timer
  wire [7:0] therm_reg;  // thermal_guard_control
  wire [7:0] blank_reg;  // transmit_blank_control

  fsbc_reg8 #(
    .ADDR (`FSBC_ADDR_TIMER),
    .RST  (`FSBC_RST_TIMER),
    .MASK (`FSBC_MASK_ALL)
  ) u_timer_reg (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .q         (timer_reg)
  );

  fsbc_reg8 #(
    .ADDR (`FSBC_ADDR_THERM),
    .RST  (`FSBC_RST_THERM),
    .MASK (`FSBC_MASK_THERM)
  ) u_therm_reg (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .q         (therm_reg)
  );

  fsbc_reg8 #(
    .ADDR (`FSBC_ADDR_BLANK),
    .RST  (`FSBC_RST_BLANK),
    .MASK (`FSBC_MASK_ALL)
  ) u_blank_reg (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .q         (blank_reg)
  );

  // field views
  wire       watchdog_on             = timer_reg[`FSBC_WDOG_ON];
  wire [1:0] watchdog_timeout_select = timer_reg[`FSBC_WDOG_SEL_HI:`FSBC_WDOG_SEL_LO];
  wire       safety_timer_behaviour  = timer_reg[`FSBC_SAFE_MODE];
  wire [3:0] safety_time_select      = timer_reg[`FSBC_SAFE_SEL_HI:`FSBC_SAFE_SEL_LO];
  wire       safety_restart_policy   = therm_reg[`FSBC_RESTART_POL];
  wire       thermistor_guard_on     = therm_reg[`FSBC_THERM_ON];
  wire       tx_blank_on             = blank_reg[`FSBC_BLANK_ON];
  wire       tx_blank_polarity       = blank_reg[`FSBC_BLANK_POL];
  wire [1:0] blank_recovery_time     = blank_reg[`FSBC_REC_HI:`FSBC_REC_LO];

  // threshold code straight to the comparator dac
  assign thermistor_threshold = therm_reg[`FSBC_THERM_THR_HI:`FSBC_THERM_THR_LO];
  // cap code straight to the input limiter
  assign blank_input_current_cap = blank_reg[`FSBC_CAP_HI:`FSBC_CAP_LO];

  // register readback, one cycle after the read strobe
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `FSBC_READ_NONE;
    end else if (reg_rd) begin
      case (reg_addr)
        `FSBC_ADDR_TIMER: reg_rdata <= timer_reg;
        `FSBC_ADDR_THERM: reg_rdata <= therm_reg;
        `FSBC_ADDR_BLANK: reg_rdata <= blank_reg;
        default:          reg_rdata <= `FSBC_READ_NONE;
      endcase
    end
  end

  // timer limits from the selected codes
  // safety limit steps
  wire [31:0] safety_limit = ({28'h0000000, safety_time_select} + 32'h00000001)
                             * SAFETY_STEP_CYC;
  wire [31:0] wdog_limit   = ({30'h00000000, watchdog_timeout_select} + 32'h00000001)
                             * WDOG_STEP_CYC;
  wire [31:0] rec_limit    = REC_BASE_CYC << blank_recovery_time;

  // watchdog: restarted by any register write
  wire wdog_done;
  fsbc_timer #(.W(32)) u_wdog (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (!watchdog_on || reg_wr),
    .run      (watchdog_on),
    .limit    (wdog_limit),
    .done     (wdog_done)
  );

  // sticky until a write; a fresh trip in the write cycle wins, a standing one is cleared
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_tripped <= 1'b0;
    end else if (watchdog_on && wdog_done && !watchdog_tripped) begin
      watchdog_tripped <= 1'b1;
    end else if (reg_wr) begin
      watchdog_tripped <= 1'b0;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      thermistor_cut <= 1'b0;
    end else begin
      thermistor_cut <= thermistor_guard_on && thermistor_hot;
    end
  end

  // transmit blanking and its recovery window
  // enable and polarity
  wire blank_now = tx_blank_on && (tx_blank_input == tx_blank_polarity);
  reg  rec_pending;  // recovery window still open after blanking ends
  wire rec_done;

  fsbc_timer #(.W(32)) u_rec (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (blank_now || !rec_pending),
    .run      (rec_pending),
    .limit    (rec_limit),
    .done     (rec_done)
  );

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rec_pending        <= 1'b0;
      blank_limit_active <= 1'b0;
    end else begin
      if (blank_now) begin
        rec_pending <= 1'b1;
      end else if (rec_done) begin
        rec_pending <= 1'b0;
      end
      blank_limit_active <= blank_now || (rec_pending && !rec_done);
    end
  end

  // flash requests
  // pin or register control
  wire want1     = fsbc_want(flash_mode_code, 1'b0, lamp_gate_input);
  wire want2     = fsbc_want(flash_mode_code, 1'b1, lamp_gate_input);
  wire want_any  = want1 || want2;
  wire pin_mode  = flash_mode_code[2] && (flash_mode_code[1] || flash_mode_code[0]);
  wire blocked   = watchdog_tripped || thermistor_cut;
  reg  want_q;      // previous request, for edge detection
  reg  shot1;       // outputs latched for a one-shot flash
  reg  shot2;
  reg  [4:0] state;
  reg  [4:0] next_state;
  reg  next_led1;
  reg  next_led2;
  wire want_rise = want_any && !want_q;

  // pin-low hold time before the safety timer may restart
  wire hold_done;
  fsbc_timer #(.W(32)) u_hold (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (want_any),
    .run      (!want_any),
    .limit    (HOLD_LOW_CYC),
    .done     (hold_done)
  );

  wire restart_ok = !want_any && (safety_restart_policy || !pin_mode || hold_done);

  // safety timer runs only while light is actually produced
  wire safety_done;
  wire lit_on = (state == ST_LIT) && want_any && !blocked;
  fsbc_timer #(.W(32)) u_safety (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (state == ST_IDLE),
    .run      ((state == ST_SHOT) || lit_on),
    .limit    (safety_limit),
    .done     (safety_done)
  );

  // sequencer next state and output drive
  always @* begin
    next_state = state;
    next_led1  = 1'b0;
    next_led2  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (!logic_supply_ok) begin
          next_state = ST_DOWN;
        end else if (want_rise && !blocked) begin
          if (!safety_timer_behaviour) begin
            next_state = ST_SHOT;
          end else begin
            next_state = ST_LIT;
          end
        end
      end
      ST_SHOT: begin
        if (!logic_supply_ok) begin
          next_state = ST_DOWN;
        end else if (safety_done || blocked) begin
          next_state = ST_IDLE;
        end else begin
          next_led1 = shot1;
          next_led2 = shot2;
        end
      end
      ST_LIT: begin
        if (safety_done) begin
          next_state = ST_SPENT;
        end else if (restart_ok) begin
          next_state = ST_IDLE;
        end else begin
          next_led1 = want1 && !blocked;
          next_led2 = want2 && !blocked;
        end
      end
      ST_SPENT: begin
        // dark until the restart condition is met
        if (restart_ok) begin
          next_state = ST_IDLE;
        end
      end
      ST_DOWN: begin
        // powered down until the logic supply returns
        if (logic_supply_ok) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer registers; outputs come from flops, one cycle behind
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state               <= ST_IDLE;
      want_q              <= 1'b0;
      shot1               <= 1'b0;
      shot2               <= 1'b0;
      first_flash_output  <= 1'b0;
      second_flash_output <= 1'b0;
      power_down          <= 1'b0;
      safety_expired      <= 1'b0;
    end else begin
      state               <= next_state;
      want_q              <= want_any;
      first_flash_output  <= next_led1;
      second_flash_output <= next_led2;
      power_down          <= (next_state == ST_DOWN);
      safety_expired      <= (next_state == ST_SPENT);
      // capture which outputs a one-shot drives, then ignore inputs
      if (state == ST_IDLE) begin
        shot1 <= want1;
        shot2 <= want2;
      end
    end
  end

endmodule
`default_nettype wire

// file: testbench/fsbc_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// pin-level checker for the flash safety and blank control bank
module fsbc_chk #(
  parameter [31:0] MS_CYCLES = 32'd100000,
  parameter [31:0] US_CYCLES = 32'd100
) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] flash_mode_code,
  input wire logic       lamp_gate_input,
  input wire logic       tx_blank_input,
  input wire logic       logic_supply_ok,
  input wire logic       thermistor_hot,
  input wire logic       first_flash_output,
  input wire logic       second_flash_output,
  input wire logic       power_down,
  input wire logic       safety_expired,
  input wire logic       watchdog_tripped,
  input wire logic       thermistor_cut,
  input wire logic [2:0] thermistor_threshold,
  input wire logic       blank_limit_active,
  input wire logic [3:0] blank_input_current_cap
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // longest legal lit run, code fifteen, plus the output flop lag
  localparam logic [31:0] CEIL = 32'd800 * MS_CYCLES + 32'd2;
  logic [31:0] lit_cnt;  // consecutive lit cycles of the first output

  // count lit cycles; a dark cycle starts the run again
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lit_cnt <= 32'h0;
    end else if (first_flash_output) begin
      lit_cnt <= lit_cnt + 32'h1;
    end else begin
      lit_cnt <= 32'h0;
    end
  end

  sequence s_rd_therm;
    reg_rd && reg_addr == 8'h0B;
  endsequence
  sequence s_wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_dark;
    !first_flash_output && !second_flash_output;
  endsequence

  AST_RSVD_ZERO:
    assert property (s_rd_therm |=> reg_rdata[6:4] == 3'h0) else $error("reserved bits set");
  AST_THR_FOLLOWS:
    assert property (s_wr_at(8'h0B) |=> {5'h0, thermistor_threshold} == ($past(reg_wdata) & 8'h07))
    else $error("threshold not taken");
  AST_CAP_FOLLOWS:
    assert property (s_wr_at(8'h0C) |=>
      {2'h0, blank_input_current_cap, 2'h0} == ($past(reg_wdata) & 8'h3C)) else $error("cap not taken");
  AST_COOL_NO_CUT:
    assert property (!thermistor_hot |=> !thermistor_cut) else $error("cut without heat");
  AST_CUT_DARK:
    assert property (thermistor_cut [*3] |-> s_dark) else $error("lit while hot");
  AST_WDOG_DARK:
    assert property (watchdog_tripped [*3] |-> s_dark) else $error("lit after watchdog trip");
  AST_WDOG_CLEAR:
    assert property ($fell(watchdog_tripped) |-> $past(reg_wr)) else $error("trip cleared alone");
  AST_PWR_DARK:
    assert property (power_down |-> s_dark) else $error("lit in power-down");
  AST_SAFETY_CEIL:
    assert property (lit_cnt <= CEIL) else $error("flash beyond ceiling");
  AST_EXPIRE_OFF:
    assert property ($rose(safety_expired) |-> ##[0:3] s_dark) else $error("lit after expiry");
endmodule

bind fsbc_top fsbc_chk #(.MS_CYCLES(MS_CYCLES), .US_CYCLES(US_CYCLES)) i_chk (
  .core_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .flash_mode_code, .lamp_gate_input, .tx_blank_input, .logic_supply_ok,
  .thermistor_hot, .first_flash_output, .second_flash_output, .power_down,
  .safety_expired, .watchdog_tripped, .thermistor_cut, .thermistor_threshold,
  .blank_limit_active, .blank_input_current_cap
);
`default_nettype wire

// file: testbench/fsbc_host.sv
`timescale 1ns/1ns
`default_nettype none
// host model: register strobes and the lamp gate pin
module fsbc_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       lamp_gate_input
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 8'h00;
    lamp_gate_input = 1'b0;
  end
  // one write; idle bus shows inverted values, never stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // one read; data is registered on the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
  task automatic set_gate(input logic v);
    @(posedge core_clk);
    lamp_gate_input <= v;
  endtask
  task automatic gate_low(input int cyc);
    set_gate(1'b0);
    repeat (cyc) @(posedge core_clk);
    lamp_gate_input <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: testbench/flash_safety_and_blank_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module flash_safety_and_blank_control_tb_top;
  localparam int MS = 4;  // one millisecond shrunk to four cycles
  localparam int US = 2;
  logic core_clk, nrst, reg_wr, reg_rd, lamp_gate_input, tx_blank_input;
  logic logic_supply_ok, thermistor_hot, first_flash_output, second_flash_output;
  logic power_down, safety_expired, watchdog_tripped, thermistor_cut, blank_limit_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, a, d, d2;
  logic [7:0] sh [0:3];  // shadow of the mapped registers
  logic [2:0] flash_mode_code, thermistor_threshold;
  logic [3:0] blank_input_current_cap;
  int err_total, n_compared, seed, n;

  fsbc_top #(.MS_CYCLES(32'(MS)), .US_CYCLES(32'(US))) i_dut (
    .core_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .flash_mode_code, .lamp_gate_input, .tx_blank_input, .logic_supply_ok,
    .thermistor_hot, .first_flash_output, .second_flash_output, .power_down,
    .safety_expired, .watchdog_tripped, .thermistor_cut, .thermistor_threshold,
    .blank_limit_active, .blank_input_current_cap);
  fsbc_host i_host (.core_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .lamp_gate_input);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // hang guard, well past the expected run length
  initial begin
    #600000;
    err_total++;
    finish_test();
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic int safe_cyc(input logic [3:0] c);
    return (c + 1) * 50 * MS;
  endfunction
  // read-back value: reserved therm bits drop, holes read zero
  function automatic logic [7:0] rb(input logic [7:0] ad, input logic [7:0] v);
    return ad == 8'h0B ? (v & 8'h8F) : ((ad == 8'h0A || ad == 8'h0C) ? v : 8'h00);
  endfunction
  // wait up to 50 cycles for light, then count lit cycles
  task automatic lit(output int cnt);
    int k;
    cnt = 0;
    k = 0;
    while (first_flash_output !== 1'b1 && k < 50) begin
      @(negedge core_clk);
      k++;
    end
    while (first_flash_output === 1'b1 && cnt < 5000) begin
      @(negedge core_clk);
      cnt++;
    end
  endtask

  initial begin
    seed = 75;
    err_total = 0;
    n_compared = 0;
    nrst = 1'b0;
    tx_blank_input = 1'b0;
    logic_supply_ok = 1'b1;
    thermistor_hot = 1'b0;
    flash_mode_code = 3'h0;
    sh[0] = 8'hC0;
    sh[3] = 8'h00;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    // blank register default, then random traffic with read-back and field outputs
    i_host.rd(8'h0C, d);
    check("rst_blank", d, 8'hC0);
    repeat (40) begin
      // random pin levels ride along with the register traffic
      @(posedge core_clk);
      thermistor_hot <= 1'($random(seed));
      tx_blank_input <= 1'($random(seed));
      logic_supply_ok <= 1'($random(seed));
      a = 8'h09 + 8'($random(seed) & 3);
      d = 8'($random(seed));
      i_host.wr(a, d);
      i_host.rd(a, d2);
      check("readback", d2, rb(a, d));
      if (a != 8'h09) sh[a[1:0]] = rb(a, d);
      check("thr", thermistor_threshold, sh[3][2:0]);
      check("cap", blank_input_current_cap, sh[0][5:2]);
      check("cut", thermistor_cut, sh[3][3] & thermistor_hot);
      check("idle_down", power_down, !logic_supply_ok);
      if (sh[0][7] && tx_blank_input == sh[0][6]) begin
        check("blank_rand", blank_limit_active, 1'b1);
      end
    end
    thermistor_hot <= 1'b0;
    logic_supply_ok <= 1'b1;
    $display("registers done");
    // one-shot at both code ends, gate dropped mid-flash
    i_host.wr(8'h0B, 8'h00);
    flash_mode_code <= 3'h5;
    for (int i = 0; i < 2; i++) begin
      i_host.wr(8'h0A, i == 0 ? 8'h00 : 8'h0F);
      i_host.set_gate(1'b1);
      fork
        lit(n);
        begin
          repeat (30) @(posedge core_clk);
          @(negedge core_clk);
          check("one_output", {first_flash_output, second_flash_output}, 2'b10);
          i_host.set_gate(1'b0);
        end
      join
      check("oneshot", n, safe_cyc(i == 0 ? 4'h0 : 4'hF));
    end
    // supply loss in mid flash
    i_host.set_gate(1'b1);
    repeat (20) @(posedge core_clk);
    logic_supply_ok <= 1'b0;
    repeat (4) @(negedge core_clk);
    check("supply_off", {first_flash_output, power_down}, 2'b01);
    i_host.set_gate(1'b0);
    logic_supply_ok <= 1'b1;
    $display("one-shot done");
    // capped flash, then both restart policies
    i_host.wr(8'h0A, 8'h10);
    i_host.set_gate(1'b1);
    lit(n);
    check("cap_len", n, safe_cyc(4'h0));
    check("expired", safety_expired, 1'b1);
    i_host.wr(8'h0B, 8'h80);
    i_host.gate_low(1);
    lit(n);
    check("imm_restart", n, safe_cyc(4'h0));
    i_host.wr(8'h0B, 8'h00);
    i_host.gate_low(20);
    lit(n);
    check("short_low", n, 0);
    i_host.gate_low(32 * MS);
    lit(n);
    check("long_low", n, safe_cyc(4'h0));
    i_host.set_gate(1'b0);
    $display("max mode done");
    // thermistor guard on and off
    i_host.wr(8'h0B, 8'h08);
    thermistor_hot <= 1'b1;
    repeat (3) @(negedge core_clk);
    check("guard_on", thermistor_cut, 1'b1);
    i_host.wr(8'h0B, 8'h00);
    repeat (3) @(negedge core_clk);
    check("guard_off", thermistor_cut, 1'b0);
    // blank recovery for every code
    for (int c = 0; c < 4; c++) begin
      i_host.wr(8'h0C, 8'hC0 | 8'(c));
      thermistor_hot <= 1'b0;
      tx_blank_input <= 1'b1;
      repeat (5) @(posedge core_clk);
      tx_blank_input <= 1'b0;
      repeat ((10 << c) * US - 3) @(negedge core_clk);
      check("blank_hold", blank_limit_active, 1'b1);
      repeat (6) @(negedge core_clk);
      check("blank_drop", blank_limit_active, 1'b0);
    end
    i_host.wr(8'h0C, 8'h80);
    repeat (3) @(negedge core_clk);
    check("active_low", blank_limit_active, 1'b1);
    i_host.wr(8'h0C, 8'h40);
    tx_blank_input <= 1'b1;
    repeat (30) @(negedge core_clk);
    check("blank_off", blank_limit_active, 1'b0);
    $display("blank done");
    // watchdog: shortest span, then disabled
    i_host.wr(8'h0A, 8'h80);
    repeat (4000 * MS - 10) @(negedge core_clk);
    check("wd_early", watchdog_tripped, 1'b0);
    repeat (20) @(negedge core_clk);
    check("wd_trip", watchdog_tripped, 1'b1);
    i_host.wr(8'h0A, 8'h00);
    repeat (4000 * MS + 20) @(negedge core_clk);
    check("wd_off", watchdog_tripped, 1'b0);
    $display("watchdog done");
    finish_test();
  end
endmodule
`default_nettype wire
